// ===== logic/dssa_alu.sv
// Saturating and subtracting packed-arithmetic datapath with AHB-Lite
// control/status registers and one level interrupt.
// Assumes decode supplies one operation per valid cycle on ref_clk.
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module dssa_alu (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Operation request from decode
   input wire logic req_valid,
   input wire dssa_pkg::dssa_op_t req_op,
   input wire logic exchange_select,
   input wire logic [31:0] first_source,
   input wire logic [31:0] second_source,
   input wire logic [4:0] width_code,
   input wire logic asr_lsl_select,
   input wire logic [2:0] amount_high_bits,
   input wire logic [1:0] amount_low_bits,
   input wire logic carry_flag,
   input wire logic [3:0] dest_index,
   input wire logic [3:0] first_index,
   input wire logic [3:0] second_index,
   // Operation answer
   output logic result_valid,
   output logic [31:0] result,
   output logic [3:0] greater_equal_flags,
   output logic saturation_flag,
   output logic undefined_op,
   output logic unpredictable_op,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Interrupt
   output logic irq
);

   // ==========================================================
   // Register bus
   logic [1:0] ctrl_reg;
   logic [2:0] irq_status_reg;
   logic [2:0] irq_status_next;
   logic [2:0] irq_mask_reg;
   logic [2:0] events;
   logic wr_pend_reg;
   logic rd_pend_reg;
   logic [7:0] ap_addr_reg;
   logic ap_take;
   logic wr_data;
   logic rd_capture;
   logic sat_clear;
   logic dsp_en;
   logic main_en;
   logic unused_bits;

   assign ap_take = hsel && htrans[dssa_pkg::HTRANS_ACTIVE_BIT] && hready;
   assign wr_data = wr_pend_reg;
   assign rd_capture = rd_pend_reg;
   assign dsp_en = ctrl_reg[dssa_pkg::CTRL_DSP_BIT];
   assign main_en = ctrl_reg[dssa_pkg::CTRL_MAIN_BIT];
   assign sat_clear = wr_data && (ap_addr_reg == dssa_pkg::ADDR_FLAGS) &&
                      hwdata[dssa_pkg::FLAGS_SAT_BIT];
   assign unused_bits = ^{hsize, haddr[31:8], carry_flag};

   // Address phase capture; reads take one wait state
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         ap_addr_reg <= 8'h00;
         hreadyout <= 1'b1;
      end else begin
         wr_pend_reg <= ap_take && hwrite;
         rd_pend_reg <= ap_take && !hwrite;
         hreadyout <= !(ap_take && !hwrite);
         if (ap_take) begin
            ap_addr_reg <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_reg <= dssa_pkg::CTRL_RESET;
         irq_mask_reg <= dssa_pkg::IRQ_MASK_RESET;
      end else if (wr_data) begin
         if (ap_addr_reg == dssa_pkg::ADDR_CTRL) begin
            ctrl_reg <= hwdata[1:0];
         end
         if (ap_addr_reg == dssa_pkg::ADDR_IRQ_MASK) begin
            irq_mask_reg <= hwdata[2:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         hrdata <= 32'h00000000;
         hresp <= 1'b0;
      end else if (rd_capture) begin
         unique case (ap_addr_reg)
            dssa_pkg::ADDR_CTRL: hrdata <= {30'h00000000, ctrl_reg};
            dssa_pkg::ADDR_FLAGS: hrdata <= {27'h0000000, saturation_flag, greater_equal_flags};
            dssa_pkg::ADDR_IRQ_STATUS: hrdata <= {29'h00000000, irq_status_reg};
            dssa_pkg::ADDR_IRQ_MASK: hrdata <= {29'h00000000, irq_mask_reg};
            dssa_pkg::ADDR_RESULT: hrdata <= result;
            default: hrdata <= 32'h00000000;
         endcase
      end
   end

   // ==========================================================
   // Operation decode
   logic is_dsp_op;
   logic is_clamp;
   logic alias_dual;
   logic do_dual_clamp;
   logic undef_now;
   logic unpred_now;
   logic swap;
   logic [4:0] shift_amount;
   logic [31:0] operand2;
   logic [31:0] shifted;
   logic [32:0] word_clamp;
   logic [32:0] low_clamp;
   logic [32:0] high_clamp;
   logic [5:0] half_width;
   logic [16:0] cross_sum;
   logic [16:0] cross_diff;
   logic [16:0] pair_lo;
   logic [16:0] pair_hi;
   logic [8:0] byte_diff [4];
   logic accept;
   logic clamp_hit;

   function automatic logic bad_reg(input logic [3:0] idx);
      return (idx == dssa_pkg::REG_STACK) || (idx == dssa_pkg::REG_PROGRAM);
   endfunction

   assign is_clamp = (req_op == dssa_pkg::signed_clamp_op);
   assign shift_amount = {amount_high_bits, amount_low_bits};
   assign alias_dual = is_clamp && asr_lsl_select && (shift_amount == 5'h00);
   assign do_dual_clamp = (req_op == dssa_pkg::dual_halfword_clamp_op) || alias_dual;
   assign is_dsp_op = !is_clamp || alias_dual;
   assign undef_now = is_dsp_op ? !dsp_en : !main_en;
   assign unpred_now = bad_reg(dest_index) || bad_reg(first_index) ||
                       (!is_clamp && !do_dual_clamp && bad_reg(second_index));
   assign accept = req_valid && !undef_now;

   assign swap = exchange_select || (req_op == dssa_pkg::dual_mul_difference_swapped_op);
   assign operand2 = swap ? {second_source[15:0], second_source[31:16]} : second_source;

   // Shift without carry path: carry_flag is left untouched
   assign shifted = asr_lsl_select ? 32'($signed(first_source) >>> shift_amount) :
                                     (first_source << shift_amount);
   assign word_clamp = dssa_pkg::clamp_word(shifted, {1'b0, width_code} + dssa_pkg::WIDTH_BIAS);
   assign half_width = {2'b00, width_code[3:0]} + dssa_pkg::WIDTH_BIAS;
   assign low_clamp = dssa_pkg::clamp_word({{16{first_source[15]}}, first_source[15:0]},
                                           half_width);
   assign high_clamp = dssa_pkg::clamp_word({{16{first_source[31]}}, first_source[31:16]},
                                            half_width);
   assign clamp_hit = do_dual_clamp ? (low_clamp[32] || high_clamp[32]) :
                      (is_clamp && word_clamp[32]);

   assign cross_sum = dssa_pkg::add17(first_source[15:0], second_source[31:16]);
   assign cross_diff = dssa_pkg::sub17(first_source[31:16], second_source[15:0]);
   assign pair_lo = dssa_pkg::sub17(first_source[15:0], second_source[15:0]);
   assign pair_hi = dssa_pkg::sub17(first_source[31:16], second_source[31:16]);

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         byte_diff[i] = dssa_pkg::sub9(first_source[8*i +: 8], second_source[8*i +: 8]);
      end
   end

   // ==========================================================
   // Result and flags
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         result <= 32'h00000000;
      end else if (accept) begin
         if (do_dual_clamp) begin
            result <= {high_clamp[15:0], low_clamp[15:0]};
         end else begin
            unique case (req_op)
               dssa_pkg::dual_mul_difference_op,
               dssa_pkg::dual_mul_difference_swapped_op:
                  result <= dssa_pkg::mul_diff(first_source, operand2);
               dssa_pkg::signed_clamp_op: result <= word_clamp[31:0];
               dssa_pkg::cross_sub_add_op: result <= {cross_diff[15:0], cross_sum[15:0]};
               dssa_pkg::halfword_pair_subtract_op:
                  result <= {pair_hi[15:0], pair_lo[15:0]};
               dssa_pkg::byte_quad_subtract_op:
                  result <= {byte_diff[3][7:0], byte_diff[2][7:0],
                             byte_diff[1][7:0], byte_diff[0][7:0]};
               default: result <= result;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         greater_equal_flags <= dssa_pkg::GE_RESET;
      end else if (accept && !do_dual_clamp) begin
         unique case (req_op)
            dssa_pkg::cross_sub_add_op:
               greater_equal_flags <= {{2{~cross_diff[16]}}, {2{~cross_sum[16]}}};
            dssa_pkg::halfword_pair_subtract_op:
               greater_equal_flags <= {{2{~pair_hi[16]}}, {2{~pair_lo[16]}}};
            dssa_pkg::byte_quad_subtract_op:
               greater_equal_flags <= {~byte_diff[3][8], ~byte_diff[2][8],
                                       ~byte_diff[1][8], ~byte_diff[0][8]};
            default: greater_equal_flags <= greater_equal_flags;
         endcase
      end
   end

   // Sticky flag: a clamp in the clearing cycle wins
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         saturation_flag <= 1'b0;
      end else if (accept && clamp_hit) begin
         saturation_flag <= 1'b1;
      end else if (sat_clear) begin
         saturation_flag <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         result_valid <= 1'b0;
         undefined_op <= 1'b0;
         unpredictable_op <= 1'b0;
      end else begin
         result_valid <= accept;
         undefined_op <= req_valid && undef_now;
         unpredictable_op <= req_valid && unpred_now;
      end
   end

   // ==========================================================
   // Interrupt status, cleared by reading it; new events win
   assign events[dssa_pkg::IRQ_SAT_BIT] = accept && clamp_hit;
   assign events[dssa_pkg::IRQ_UNDEF_BIT] = req_valid && undef_now;
   assign events[dssa_pkg::IRQ_UNPRED_BIT] = req_valid && unpred_now;

   always_comb begin
      irq_status_next = irq_status_reg;
      if (rd_capture && (ap_addr_reg == dssa_pkg::ADDR_IRQ_STATUS)) begin
         irq_status_next = 3'h0;
      end
      irq_status_next = irq_status_next | events;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         irq_status_reg <= 3'h0;
         irq <= 1'b0;
      end else begin
         irq_status_reg <= irq_status_next;
         irq <= |(irq_status_next & ((wr_data && ap_addr_reg == dssa_pkg::ADDR_IRQ_MASK) ?
                                     hwdata[2:0] : irq_mask_reg));
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_swap_rotate: assert property (accept && swap &&
      (req_op == dssa_pkg::dual_mul_difference_swapped_op) |=>
      result == dssa_pkg::mul_diff($past(first_source),
         {$past(second_source[15:0]), $past(second_source[31:16])}))
      else $error("swapped multiply difference wrong");
   a_mul_plain: assert property (accept && !swap &&
      (req_op == dssa_pkg::dual_mul_difference_op) |=>
      result == dssa_pkg::mul_diff($past(first_source), $past(second_source)))
      else $error("multiply difference wrong");
   a_clamp_range: assert property (accept && is_clamp && !alias_dual |=>
      dssa_pkg::clamp_word(result, {1'b0, $past(width_code)} + dssa_pkg::WIDTH_BIAS) <
      33'h100000000) else $error("clamp result out of range");
   a_alias_dual: assert property (req_valid && alias_dual && dsp_en |=>
      result_valid && !undefined_op) else $error("shift zero alias not dual clamp");
   a_sat_set: assert property (accept && clamp_hit |=> saturation_flag ##1
      (saturation_flag || $past(sat_clear))) else $error("saturation flag not sticky");
   a_sat_hold: assert property ($fell(saturation_flag) |-> $past(sat_clear))
      else $error("saturation flag cleared by hardware");
   a_cross_ge: assert property (accept && req_op == dssa_pkg::cross_sub_add_op |=>
      greater_equal_flags[1:0] == {2{~$past(cross_sum[16])}} &&
      greater_equal_flags[3:2] == {2{~$past(cross_diff[16])}})
      else $error("cross GE flags wrong");
   a_byte_ge: assert property (accept && req_op == dssa_pkg::byte_quad_subtract_op |=>
      greater_equal_flags[0] == ~$past(byte_diff[0][8]) &&
      greater_equal_flags[3] == ~$past(byte_diff[3][8]))
      else $error("byte GE flags wrong");
   a_undef_block: assert property (req_valid && is_dsp_op && !dsp_en |=>
      undefined_op && !result_valid && $stable(result))
      else $error("undefined operation executed");
   a_unpred_flag: assert property (req_valid && bad_reg(dest_index) |=>
      unpredictable_op) else $error("bad register not flagged");
   a_irq_level: assert property (irq == |(irq_status_reg & irq_mask_reg))
      else $error("interrupt level mismatch");
   a_swap_select: assert property (accept && exchange_select &&
      req_op == dssa_pkg::dual_mul_difference_op |=> result == dssa_pkg::mul_diff(
      $past(first_source), {$past(second_source[15:0]), $past(second_source[31:16])}))
      else $error("exchange ignored");
   a_ge_keep: assert property (accept && req_op < dssa_pkg::cross_sub_add_op |=>
      $stable(greater_equal_flags)) else $error("flags changed");
   a_pair_sub: assert property (accept &&
      req_op == dssa_pkg::halfword_pair_subtract_op |=> result ==
      {16'($past(first_source[31:16]) - $past(second_source[31:16])),
       16'($past(first_source[15:0]) - $past(second_source[15:0]))})
      else $error("pair difference wrong");
   a_cross_sum: assert property (accept && req_op == dssa_pkg::cross_sub_add_op |=>
      result == {16'($past(first_source[31:16]) - $past(second_source[15:0])),
      16'($past(first_source[15:0]) + $past(second_source[31:16]))})
      else $error("cross result wrong");
   a_byte_sub: assert property (accept &&
      req_op == dssa_pkg::byte_quad_subtract_op |=>
      result[7:0] == 8'($past(first_source[7:0]) - $past(second_source[7:0])) &&
      result[31:24] == 8'($past(first_source[31:24]) - $past(second_source[31:24])))
      else $error("byte difference wrong");
   a_dual_range: assert property (accept && do_dual_clamp |=>
      dssa_pkg::clamp_word({{16{result[31]}}, result[31:16]}, $past(half_width)) <
      33'h100000000 &&
      dssa_pkg::clamp_word({{16{result[15]}}, result[15:0]}, $past(half_width)) <
      33'h100000000) else $error("dual clamp out of range");
   a_main_undef: assert property (req_valid && is_clamp && !alias_dual && !main_en
      |=> undefined_op && !result_valid) else $error("clamp ran without option");
   a_unpred_exec: assert property (req_valid && unpred_now && !undef_now |=>
      unpredictable_op && result_valid) else $error("unpredictable op dropped");
   a_result_hold: assert property (!accept |=> $stable(result))
      else $error("result changed unasked");

   c_clamp_hit: cover property (accept && is_clamp && clamp_hit);
   c_dual_alias: cover property (req_valid && alias_dual);
   c_sub8_mixed: cover property (accept && req_op == dssa_pkg::byte_quad_subtract_op
      && byte_diff[0][8] && !byte_diff[1][8]);
   c_irq_read: cover property (irq ##[1:20] rd_capture && ap_addr_reg == dssa_pkg::ADDR_IRQ_STATUS);
   c_main_undef: cover property (req_valid && is_clamp && !alias_dual && !main_en);

endmodule // dssa_alu
`default_nettype wire

// ===== logic/dssa_pkg.sv
// Shared constants, operation codes and arithmetic helpers of the
// saturating subtract datapath. Assumes a 32-bit AHB-Lite register bus.
package dssa_pkg;

   // ==========================================================
   // Operation codes
   typedef enum logic [2:0] {
      dual_mul_difference_op,
      dual_mul_difference_swapped_op,
      signed_clamp_op,
      dual_halfword_clamp_op,
      cross_sub_add_op,
      halfword_pair_subtract_op,
      byte_quad_subtract_op
   } dssa_op_t;

   // ==========================================================
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FLAGS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_RESULT = 8'h10;

   // ==========================================================
   // Field positions and reset values
   localparam int CTRL_DSP_BIT = 0;
   localparam int CTRL_MAIN_BIT = 1;
   localparam int FLAGS_SAT_BIT = 4;
   localparam int IRQ_SAT_BIT = 0;
   localparam int IRQ_UNDEF_BIT = 1;
   localparam int IRQ_UNPRED_BIT = 2;
   localparam int HTRANS_ACTIVE_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
   localparam logic [3:0] GE_RESET = 4'h0;
   localparam logic [3:0] REG_STACK = 4'hD;
   localparam logic [3:0] REG_PROGRAM = 4'hF;
   localparam logic [5:0] WIDTH_BIAS = 6'h01;

   // ==========================================================
   // Arithmetic helpers
   // Signed clamp to n bits (1..32); bit 32 flags a clamp
   function automatic logic [32:0] clamp_word(input logic [31:0] v, input logic [5:0] n);
      logic signed [33:0] vx;
      logic signed [33:0] maxv;
      logic signed [33:0] minv;
      logic [32:0] r;
      vx = $signed({{2{v[31]}}, v});
      maxv = (34'sh1 <<< (n - WIDTH_BIAS)) - 34'sh1;
      minv = ~maxv;
      if (vx > maxv) r = {1'b1, maxv[31:0]};
      else if (vx < minv) r = {1'b1, minv[31:0]};
      else r = {1'b0, v};
      return r;
   endfunction

   // Low product minus high product, low 32 bits kept
   function automatic logic [31:0] mul_diff(input logic [31:0] a, input logic [31:0] b);
      logic signed [31:0] p1;
      logic signed [31:0] p2;
      p1 = $signed(a[15:0]) * $signed(b[15:0]);
      p2 = $signed(a[31:16]) * $signed(b[31:16]);
      return 32'(p1 - p2);
   endfunction

   // 17-bit signed difference and sum of halves
   function automatic logic [16:0] sub17(input logic [15:0] a, input logic [15:0] b);
      return {a[15], a} - {b[15], b};
   endfunction

   function automatic logic [16:0] add17(input logic [15:0] a, input logic [15:0] b);
      return {a[15], a} + {b[15], b};
   endfunction

   // 9-bit signed byte difference
   function automatic logic [8:0] sub9(input logic [7:0] a, input logic [7:0] b);
      return {a[7], a} - {b[7], b};
   endfunction

endpackage

// ===== testbench/dssa_regfile_model.sv
// Operand register file standing in for decode and operand fetch.
// Assumes the bench loads operands one word per clock before a request.
`timescale 1ns/1ps
`default_nettype none

module dssa_regfile_model (
   // Clock
   input wire logic ref_clk,
   // Load port from the bench
   input wire logic load_en,
   input wire logic [3:0] load_index,
   input wire logic [31:0] load_data,
   // Operand fetch
   input wire logic [3:0] first_index,
   input wire logic [3:0] second_index,
   output logic [31:0] first_source,
   output logic [31:0] second_source
);
   logic [31:0] regs [16];

   // ==========================================================
   // Load and fetch
   always_ff @(posedge ref_clk) begin
      if (load_en) begin
         regs[load_index] <= load_data;
      end
   end

   // Issuer names 13 or 15 only when told to
   always_comb begin
      first_source = regs[first_index];
      second_source = regs[second_index];
   end
endmodule // dssa_regfile_model

`default_nettype wire

// ===== testbench/dssa_alu_bench.sv
// Self-checking bench of the saturating subtract datapath.
// Assumes one AHB-Lite slave and a register file model feeding operands.
`timescale 1ns/1ps
`default_nettype none

`define dssa_chk(n, e, g) \
   begin \
      checked++; \
      if ((g) !== (e)) begin \
         bad_count++; \
         $display("unexpected %s expected %h seen %h", n, e, g); \
      end \
   end

module dssa_alu_bench;
   localparam dssa_pkg::dssa_op_t o_sub16 = dssa_pkg::halfword_pair_subtract_op;
   localparam dssa_pkg::dssa_op_t o_sub8 = dssa_pkg::byte_quad_subtract_op;
   localparam dssa_pkg::dssa_op_t o_cross = dssa_pkg::cross_sub_add_op;
   localparam dssa_pkg::dssa_op_t o_mul = dssa_pkg::dual_mul_difference_op;
   localparam dssa_pkg::dssa_op_t o_mulx = dssa_pkg::dual_mul_difference_swapped_op;
   localparam dssa_pkg::dssa_op_t o_clamp = dssa_pkg::signed_clamp_op;
   localparam dssa_pkg::dssa_op_t o_clamp2 = dssa_pkg::dual_halfword_clamp_op;
   localparam int limit = 2000;

   typedef struct {
      dssa_pkg::dssa_op_t op;
      logic x;
      logic [31:0] a;
      logic [31:0] b;
      logic [4:0] w;
      logic [5:0] sa;
      logic [31:0] res;
      logic [3:0] ge;
      logic sat;
   } dssa_row_t;

   // ==========================================================
   // Signals
   logic ref_clk, rst_n, req_valid, exchange_select, asr_lsl_select, carry_flag;
   dssa_pkg::dssa_op_t req_op;
   logic [31:0] first_source, second_source, result, haddr, hwdata, hrdata, load_data;
   logic [4:0] width_code;
   logic [2:0] amount_high_bits, hsize;
   logic [1:0] amount_low_bits, htrans;
   logic [3:0] dest_index, first_index, second_index, greater_equal_flags, load_index;
   logic result_valid, saturation_flag, undefined_op, unpredictable_op, load_en;
   logic hsel, hwrite, hreadyout, hresp, irq;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   dssa_row_t rows [16] = '{
      '{o_sub16, 1'b0, 32'h00050003, 32'h00010007, 5'h00, 6'h00, 32'h0004FFFC, 4'hC, 1'b0},
      '{o_sub16, 1'b0, 32'h80007FFF, 32'h0001FFFF, 5'h00, 6'h00, 32'h7FFF8000, 4'h3, 1'b0},
      '{o_cross, 1'b0, 32'h00100020, 32'h00300005, 5'h00, 6'h00, 32'h000B0050, 4'hF, 1'b0},
      '{o_cross, 1'b0, 32'h00000001, 32'h00050010, 5'h00, 6'h00, 32'hFFF00006, 4'h3, 1'b0},
      '{o_sub8, 1'b0, 32'h10807F05, 32'h01017F06, 5'h00, 6'h00, 32'h0F7F00FF, 4'hA, 1'b0},
      '{o_mul, 1'b0, 32'h00030002, 32'h00050004, 5'h00, 6'h00, 32'hFFFFFFF9, 4'hA, 1'b0},
      '{o_mul, 1'b1, 32'h00030002, 32'h00050004, 5'h00, 6'h00, 32'hFFFFFFFE, 4'hA, 1'b0},
      '{o_mulx, 1'b0, 32'h00030002, 32'h00050004, 5'h00, 6'h00, 32'hFFFFFFFE, 4'hA, 1'b0},
      '{o_mul, 1'b0, 32'h80008000, 32'h7FFF8000, 5'h00, 6'h00, 32'h7FFF8000, 4'hA, 1'b0},
      '{o_clamp, 1'b0, 32'h00000005, 32'h00000000, 5'h07, 6'h02, 32'h00000014, 4'hA, 1'b0},
      '{o_clamp, 1'b0, 32'hFFFFFF00, 32'h00000000, 5'h04, 6'h24, 32'hFFFFFFF0, 4'hA, 1'b0},
      '{o_clamp, 1'b0, 32'h00000010, 32'h00000000, 5'h04, 6'h00, 32'h0000000F, 4'hA, 1'b1},
      '{o_clamp, 1'b0, 32'hC0000000, 32'h00000000, 5'h07, 6'h01, 32'hFFFFFF80, 4'hA, 1'b1},
      '{o_clamp, 1'b0, 32'h80000000, 32'h00000000, 5'h1F, 6'h3F, 32'hFFFFFFFF, 4'hA, 1'b1},
      '{o_clamp2, 1'b0, 32'h7FFF8000, 32'h00000000, 5'h07, 6'h00, 32'h007FFF80, 4'hA, 1'b1},
      '{o_clamp, 1'b0, 32'h00050010, 32'h00000000, 5'h13, 6'h20, 32'h00050007, 4'hA, 1'b1}};

   // ==========================================================
   // Design and partner
   dssa_alu i_dssa_alu (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
      .req_op(req_op), .exchange_select(exchange_select), .first_source(first_source),
      .second_source(second_source), .width_code(width_code),
      .asr_lsl_select(asr_lsl_select), .amount_high_bits(amount_high_bits),
      .amount_low_bits(amount_low_bits), .carry_flag(carry_flag), .dest_index(dest_index),
      .first_index(first_index), .second_index(second_index), .result_valid(result_valid),
      .result(result), .greater_equal_flags(greater_equal_flags),
      .saturation_flag(saturation_flag), .undefined_op(undefined_op),
      .unpredictable_op(unpredictable_op), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq));

   dssa_regfile_model i_dssa_regfile_model (.ref_clk(ref_clk), .load_en(load_en),
      .load_index(load_index), .load_data(load_data), .first_index(first_index),
      .second_index(second_index), .first_source(first_source),
      .second_source(second_source));

   // ==========================================================
   // Tasks
   task automatic tick();
      @(posedge ref_clk);
   endtask

   task automatic conclude();
      if (bad_count == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do tick(); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do tick(); while (hreadyout !== 1'b1);
      q = hrdata;
      `dssa_chk("hresp", 1'b0, hresp)
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      logic [31:0] q;
      bus(1'b0, a, 32'h00000000, q);
      `dssa_chk(n, e, q)
   endtask

   task automatic load(input logic [3:0] i, input logic [31:0] d);
      load_en <= 1'b1;
      load_index <= i;
      load_data <= d;
      tick();
   endtask

   // Ends one edge after the edge that registers the answer
   task automatic issue(input dssa_row_t r, input logic [3:0] d);
      load(4'h1, r.a);
      load(4'h2, r.b);
      load_en <= 1'b0;
      req_valid <= 1'b1;
      req_op <= r.op;
      exchange_select <= r.x;
      width_code <= r.w;
      {asr_lsl_select, amount_high_bits, amount_low_bits} <= r.sa;
      carry_flag <= ~carry_flag;
      dest_index <= d;
      first_index <= 4'h1;
      second_index <= 4'h2;
      tick();
      req_valid <= 1'b0;
      tick();
   endtask

   task automatic outs(input logic v, input logic u, input logic p);
      `dssa_chk("valid", v, result_valid)
      `dssa_chk("undef", u, undefined_op)
      `dssa_chk("unpred", p, unpredictable_op)
   endtask

   // ==========================================================
   // Clock and timeout
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == limit) begin
         bad_count++;
         conclude();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      {rst_n, req_valid, exchange_select, asr_lsl_select, carry_flag, load_en} = 6'h00;
      {hsel, hwrite, htrans, haddr, hwdata, load_data, load_index} = 104'h0;
      {width_code, amount_high_bits, amount_low_bits, hsize} = 13'h0002;
      {dest_index, first_index, second_index} = 12'h312;
      req_op = o_sub16;
      repeat (5) tick();
      rst_n <= 1'b1;
      tick();
      `dssa_chk("result", 32'h00000000, result)
      `dssa_chk("ge", 4'h0, greater_equal_flags)
      `dssa_chk("irq", 1'b0, irq)
      rd(dssa_pkg::ADDR_CTRL, 32'h00000003, "ctrl");
      rd(dssa_pkg::ADDR_IRQ_MASK, 32'h00000000, "mask");
      rd(8'h20, 32'h00000000, "unmapped");
      wr(dssa_pkg::ADDR_FLAGS, 32'h0000000F);
      rd(dssa_pkg::ADDR_FLAGS, 32'h00000000, "flags");
      foreach (rows[i]) begin
         issue(rows[i], 4'h3);
         outs(1'b1, 1'b0, 1'b0);
         `dssa_chk("result", rows[i].res, result)
         `dssa_chk("ge", rows[i].ge, greater_equal_flags)
         `dssa_chk("sat", rows[i].sat, saturation_flag)
      end
      `dssa_chk("irq", 1'b0, irq)
      wr(dssa_pkg::ADDR_IRQ_MASK, 32'h00000007);
      repeat (2) tick();
      `dssa_chk("irq", 1'b1, irq)
      rd(dssa_pkg::ADDR_IRQ_STATUS, 32'h00000001, "status");
      repeat (2) tick();
      `dssa_chk("irq", 1'b0, irq)
      rd(dssa_pkg::ADDR_FLAGS, 32'h0000001A, "flags");
      wr(dssa_pkg::ADDR_FLAGS, 32'h00000010);
      tick();
      `dssa_chk("sat", 1'b0, saturation_flag)
      wr(dssa_pkg::ADDR_CTRL, 32'h00000001);
      issue(rows[11], 4'h3);
      outs(1'b0, 1'b1, 1'b0);
      `dssa_chk("sat", 1'b0, saturation_flag)
      `dssa_chk("result", rows[15].res, result)
      issue(rows[15], 4'h3);
      outs(1'b1, 1'b0, 1'b0);
      wr(dssa_pkg::ADDR_CTRL, 32'h00000002);
      issue(rows[15], 4'h3);
      outs(1'b0, 1'b1, 1'b0);
      issue(rows[0], 4'h3);
      outs(1'b0, 1'b1, 1'b0);
      `dssa_chk("ge", 4'hA, greater_equal_flags)
      rd(dssa_pkg::ADDR_IRQ_STATUS, 32'h00000003, "status");
      wr(dssa_pkg::ADDR_CTRL, 32'h00000003);
      issue(rows[0], 4'hD);
      outs(1'b1, 1'b0, 1'b1);
      issue(rows[1], 4'hF);
      outs(1'b1, 1'b0, 1'b1);
      `dssa_chk("result", rows[1].res, result)
      rd(dssa_pkg::ADDR_IRQ_STATUS, 32'h00000004, "status");
      rd(dssa_pkg::ADDR_RESULT, rows[1].res, "result_reg");
      conclude();
   end
endmodule // dssa_alu_bench

`default_nettype wire
